/* File: design/clock_pkg.sv */
/*
 Constants shared by the time-of-day counter chain: segment patterns, clock rate,
 tick dividers and the register map of the AXI4-Lite slave.
 Assumes a single 50 MHz reference clock and active-high segment drive.
*/
// Functional notes
// - Hold clears both seconds digits, keeps them zero.
// - Tens of seconds wraps after six states.
// - Tens MSB changes leaving counts three and five.
// - Seconds advance from the one hertz tick.
// - Minutes/hours pulse: per minute, 8 Hz, 128 Hz.
// - Reference clock input runs the prescaler.
// - Minute digit state is its segment pattern.
// - Segment A dark after states zero, three, five, unless that state is the last.
// - Reset shows zero: A-F lit, G dark.
// - Carry at last state enables next stage.
// - Tens of minutes steps zero to five.
// - Hours is one stage, resets to twelve.
// - Hours carry when count reaches twelve.
// - Meridiem flag toggles on every hours carry.
// - Clock reset forces morning flag at once.
// - Seconds and minutes count 00 to 59.
// - Hours count 1 to 12, never 00.
// - Hold stops minutes and hours, seconds zero.
// - Both set switches, with hold off, reset time to 12:00 AM.
package clock_pkg;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned FAST_SET_HZ = 128;
  localparam int unsigned TICK128_CYCLES = 1_000_000_000 / (CLK_PERIOD_NS * FAST_SET_HZ);
  localparam int unsigned SLOW_SET_HZ = 8;
  localparam int unsigned TICK8_DIV = FAST_SET_HZ / SLOW_SET_HZ;
  localparam logic [3:0] HOUR_RESET = 4'hC;
  localparam logic [3:0] HOUR_FIRST = 4'h1;
  localparam logic [3:0] SEC_ONES_LAST = 4'h9;
  localparam logic [2:0] TENS_LAST = 3'h5;
  localparam logic [6:0] SEG_BLANK = 7'h00;
  localparam logic [6:0] SEG_ZERO = 7'h3F;
  localparam logic [31:0] CTRL_OFFSET = 32'h0000_0000;
  localparam logic [31:0] STATUS_OFFSET = 32'h0000_0004;
  localparam logic [31:0] SEGMENT_OFFSET = 32'h0000_0008;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Pattern bit order is {g,f,e,d,c,b,a}; six drops segment A.
  function automatic logic [6:0] seg_of(input logic [3:0] digit);
    unique case (digit)
      4'h0: seg_of = 7'h3F;
      4'h1: seg_of = 7'h06;
      4'h2: seg_of = 7'h5B;
      4'h3: seg_of = 7'h4F;
      4'h4: seg_of = 7'h66;
      4'h5: seg_of = 7'h6D;
      4'h6: seg_of = 7'h7C;
      4'h7: seg_of = 7'h07;
      4'h8: seg_of = 7'h7F;
      4'h9: seg_of = 7'h6F;
      default: seg_of = 7'h00;
    endcase
  endfunction
endpackage

/* File: design/six_state_counter.sv */
/*
 Three-bit counter with six states, synchronous clear and count enable.
 Assumes clear and enable come from logic on the same clock.
*/
`timescale 1ns/1ps
module six_state_counter (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic clr_i,
  input wire logic en_i,
  // Count
  output logic [2:0] tens_count_bits_o,
  output logic tc_o
);
  logic [2:0] cnt_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r <= 3'h0;
    end else if (clr_i) begin
      cnt_r <= 3'h0;
    end else if (en_i) begin
      cnt_r <= (cnt_r == clock_pkg::TENS_LAST) ? 3'h0 : cnt_r + 3'h1;
    end
  end

  assign tens_count_bits_o = cnt_r;
  assign tc_o = (cnt_r == clock_pkg::TENS_LAST);

  property p_tens_wrap;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      en_i && !clr_i && cnt_r == 3'h5 |=> cnt_r == 3'h0;
  endproperty
  a_tens_wrap: assert property (p_tens_wrap) else $error("tens digit did not wrap");

  property p_msb_step;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      en_i && !clr_i && cnt_r == 3'h3 |=> cnt_r[2] && $changed(cnt_r[2]);
  endproperty
  a_msb_step: assert property (p_msb_step) else $error("tens MSB did not change");
endmodule // six_state_counter

/* File: design/seg_digit_counter.sv */
/*
 Decimal digit counter whose state register is its own segment pattern.
 Assumes active-high segments; illegal patterns recover to zero.
*/
`timescale 1ns/1ps
module seg_digit_counter #(
  parameter logic [3:0] LAST_DIGIT = 4'h9
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // Control
  input wire logic clr_i,
  input wire logic en_i,
  // Segments and carry
  output logic [6:0] seg_o,
  output logic stage_carry_enable_o
);
  logic [6:0] seg_r;
  logic [6:0] seg_nxt;

  // Next pattern is decoded from the current pattern.
  always_comb begin
    seg_nxt = clock_pkg::SEG_ZERO;
    for (int i = 0; i <= int'(LAST_DIGIT); i++) begin
      if (seg_r == clock_pkg::seg_of(4'(i)) && 4'(i) != LAST_DIGIT) begin
        seg_nxt = clock_pkg::seg_of(4'(i + 1));
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      seg_r <= clock_pkg::SEG_ZERO;
    end else if (clr_i) begin
      seg_r <= clock_pkg::SEG_ZERO;
    end else if (en_i) begin
      seg_r <= seg_nxt;
    end
  end

  assign seg_o = seg_r;
  assign stage_carry_enable_o = (seg_r == clock_pkg::seg_of(LAST_DIGIT));

  property p_seg_a_dark;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      en_i && !clr_i && (seg_r == 7'h3F || seg_r == 7'h4F || seg_r == 7'h6D) &&
      !stage_carry_enable_o |=> !seg_r[0];
  endproperty
  a_seg_a_dark: assert property (p_seg_a_dark) else $error("segment A lit after 0/3/5");

  property p_digit_wrap;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      en_i && !clr_i && stage_carry_enable_o |=> seg_r == 7'h3F && !stage_carry_enable_o;
  endproperty
  a_digit_wrap: assert property (p_digit_wrap) else $error("digit did not wrap to zero");
endmodule // seg_digit_counter

/* File: design/time_of_day_display_counters.sv */
/*
 Twelve-hour time-of-day counter chain with prescaler, switch synchronisers,
 minutes and hours stages, meridiem flag and an AM/PM readable AXI4-Lite slave.
 Assumes switch pins are asynchronous levels and one AXI master on ref_clk_i.
*/
`timescale 1ns/1ps
module time_of_day_display_counters #(
  parameter int unsigned TICK128_CYCLES = clock_pkg::TICK128_CYCLES
) (
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic arst_n_i,
  // AXI4-Lite write address and data
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  // AXI4-Lite write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // AXI4-Lite read
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [31:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  // Setting switches
  input wire logic slow_set_pin_i,
  input wire logic fast_set_pin_i,
  input wire logic hold_pin_i,
  // Displays
  output logic [3:0] sec_ones_o,
  output logic [2:0] sec_tens_o,
  output logic [6:0] min_ones_seg_o,
  output logic [6:0] min_tens_seg_o,
  output logic [6:0] hr_ones_seg_o,
  output logic [6:0] hr_tens_seg_o,
  output logic pm_o
);
  // Switch synchronisers: three flops, a change counts when stages two and three agree.
  logic [2:0] pin_s1_r;
  logic [2:0] pin_s2_r;
  logic [2:0] pin_s3_r;
  logic [2:0] pin_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      pin_s3_r <= 3'h0;
    end else begin
      pin_s1_r <= {hold_pin_i, fast_set_pin_i, slow_set_pin_i};
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_r <= 3'h0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (pin_s2_r[i] == pin_s3_r[i]) begin
          pin_r[i] <= pin_s3_r[i];
        end
      end
    end
  end

  // Software switch register; either source sets a switch.
  logic [2:0] ctrl_r;
  logic slow_set;
  logic fast_set;
  logic hold;
  logic time_rst;
  logic sec_rst;

  assign slow_set = pin_r[0] | ctrl_r[0];
  assign fast_set = pin_r[1] | ctrl_r[1];
  assign hold = pin_r[2] | ctrl_r[2];
  assign time_rst = slow_set & fast_set & ~hold;
  assign sec_rst = slow_set | fast_set | hold;

  // Prescaler on the reference clock: 128 Hz, 8 Hz and 1 Hz enable pulses.
  logic [31:0] pre_cnt_r;
  logic [6:0] tick_cnt_r;
  logic tick128;
  logic tick8;
  logic tick1;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pre_cnt_r <= 32'h0000_0000;
    end else if (pre_cnt_r == TICK128_CYCLES - 1) begin
      pre_cnt_r <= 32'h0000_0000;
    end else begin
      pre_cnt_r <= pre_cnt_r + 32'h0000_0001;
    end
  end

  assign tick128 = (pre_cnt_r == TICK128_CYCLES - 1);

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt_r <= 7'h00;
    end else if (tick128) begin
      tick_cnt_r <= tick_cnt_r + 7'h01;
    end
  end

  assign tick8 = tick128 && (tick_cnt_r[3:0] == 4'(clock_pkg::TICK8_DIV - 1));
  assign tick1 = tick128 && (tick_cnt_r == 7'h7F);

  // Seconds: decimal ones digit and six-state tens digit.
  logic [3:0] sec_ones_r;
  logic [2:0] sec_tens;
  logic sec_tens_tc;
  logic sec_ones_tc;
  logic sec_carry;

  assign sec_ones_tc = (sec_ones_r == clock_pkg::SEC_ONES_LAST);
  assign sec_carry = tick1 && sec_ones_tc && sec_tens_tc;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sec_ones_r <= 4'h0;
    end else if (sec_rst) begin
      sec_ones_r <= 4'h0;
    end else if (tick1) begin
      sec_ones_r <= sec_ones_tc ? 4'h0 : sec_ones_r + 4'h1;
    end
  end

  six_state_counter u_sec_tens (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .clr_i(sec_rst),
    .en_i(tick1 && sec_ones_tc),
    .tens_count_bits_o(sec_tens),
    .tc_o(sec_tens_tc)
  );

  // Minutes and hours pulse, chosen by the switch mode.
  logic min_pulse;

  always_comb begin
    min_pulse = 1'b0;
    if (!hold) begin
      if (slow_set && !fast_set) begin
        min_pulse = tick8;
      end else if (fast_set && !slow_set) begin
        min_pulse = tick128;
      end else if (!slow_set && !fast_set) begin
        min_pulse = sec_carry;
      end
    end
  end

  logic min_ones_tc;
  logic min_tens_tc;
  logic hr_adv;

  seg_digit_counter #(
    .LAST_DIGIT(4'h9)
  ) u_min_ones (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .clr_i(time_rst),
    .en_i(min_pulse),
    .seg_o(min_ones_seg_o),
    .stage_carry_enable_o(min_ones_tc)
  );

  seg_digit_counter #(
    .LAST_DIGIT(4'h5)
  ) u_min_tens (
    .ref_clk_i(ref_clk_i),
    .arst_n_i(arst_n_i),
    .clr_i(time_rst),
    .en_i(min_pulse && min_ones_tc),
    .seg_o(min_tens_seg_o),
    .stage_carry_enable_o(min_tens_tc)
  );

  assign hr_adv = min_pulse && min_ones_tc && min_tens_tc;

  // Hours: one stage over both digits, 12, 1, 2 ... 11, 12.
  logic [3:0] hr_r;
  logic [3:0] hr_nxt;
  logic [3:0] hr_ones;
  logic hr_carry;
  logic [6:0] hr_ones_seg_r;
  logic [6:0] hr_tens_seg_r;
  logic pm_r;

  always_comb begin
    hr_nxt = hr_r;
    if (time_rst) begin
      hr_nxt = clock_pkg::HOUR_RESET;
    end else if (hr_adv) begin
      hr_nxt = (hr_r == clock_pkg::HOUR_RESET) ? clock_pkg::HOUR_FIRST : hr_r + 4'h1;
    end
  end

  assign hr_carry = hr_adv && !time_rst && (hr_nxt == clock_pkg::HOUR_RESET);
  assign hr_ones = (hr_nxt > 4'h9) ? hr_nxt - 4'hA : hr_nxt;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hr_r <= clock_pkg::HOUR_RESET;
      hr_ones_seg_r <= clock_pkg::seg_of(4'h2);
      hr_tens_seg_r <= clock_pkg::seg_of(4'h1);
    end else begin
      hr_r <= hr_nxt;
      hr_ones_seg_r <= clock_pkg::seg_of(hr_ones);
      hr_tens_seg_r <= (hr_nxt > 4'h9) ? clock_pkg::seg_of(4'h1) : clock_pkg::SEG_BLANK;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pm_r <= 1'b0;
    end else if (time_rst) begin
      pm_r <= 1'b0;
    end else if (hr_carry) begin
      pm_r <= ~pm_r;
    end
  end

  // The reset mask shows morning in the same cycle the switches ask for it.
  assign pm_o = pm_r & ~time_rst;
  assign hr_ones_seg_o = hr_ones_seg_r;
  assign hr_tens_seg_o = hr_tens_seg_r;
  assign sec_ones_o = sec_ones_r;
  assign sec_tens_o = sec_tens;

  // AXI4-Lite slave: one write and one read at a time.
  logic aw_got_r;
  logic w_got_r;
  logic [31:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic wr_do;
  logic wr_hit;

  assign awready_o = !aw_got_r && !bvalid_r;
  assign wready_o = !w_got_r && !bvalid_r;
  assign wr_do = aw_got_r && w_got_r && !bvalid_r;
  assign wr_hit = aw_addr_r == clock_pkg::CTRL_OFFSET || aw_addr_r == clock_pkg::STATUS_OFFSET ||
                  aw_addr_r == clock_pkg::SEGMENT_OFFSET;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 32'h0000_0000;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (awvalid_i && awready_o) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= {awaddr_i[31:2], 2'b00};
      end else if (wr_do) begin
        aw_got_r <= 1'b0;
      end
      if (wvalid_i && wready_o) begin
        w_got_r <= 1'b1;
        w_data_r <= wdata_i;
        w_strb_r <= wstrb_i;
      end else if (wr_do) begin
        w_got_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bvalid_r <= 1'b0;
      bresp_r <= clock_pkg::RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? clock_pkg::RESP_OKAY : clock_pkg::RESP_SLVERR;
    end else if (bready_i) begin
      bvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ctrl_r <= 3'h0;
    end else if (wr_do && aw_addr_r == clock_pkg::CTRL_OFFSET && w_strb_r[0]) begin
      ctrl_r <= w_data_r[2:0];
    end
  end

  assign arready_o = !rvalid_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= clock_pkg::RESP_OKAY;
    end else if (arvalid_i && arready_o) begin
      rvalid_r <= 1'b1;
      rresp_r <= clock_pkg::RESP_OKAY;
      unique case ({araddr_i[31:2], 2'b00})
        clock_pkg::CTRL_OFFSET: rdata_r <= {29'h0, ctrl_r};
        clock_pkg::STATUS_OFFSET: rdata_r <= {16'h0, pin_r, hold, hr_r, pm_o, sec_tens, sec_ones_r};
        clock_pkg::SEGMENT_OFFSET: rdata_r <= {4'h0, hr_tens_seg_r, hr_ones_seg_r,
                                               min_tens_seg_o, min_ones_seg_o};
        default: begin
          rdata_r <= 32'h0000_0000;
          rresp_r <= clock_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rready_i) begin
      rvalid_r <= 1'b0;
    end
  end

  assign bvalid_o = bvalid_r;
  assign bresp_o = bresp_r;
  assign rvalid_o = rvalid_r;
  assign rdata_o = rdata_r;
  assign rresp_o = rresp_r;

  sequence s_eleven_step;
    hr_adv && !time_rst && hr_r == 4'hB;
  endsequence

  sequence s_pm_flipped;
    pm_r != $past(pm_r) && hr_r == 4'hC;
  endsequence

  property p_hold_zero;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      hold |=> sec_ones_r == 4'h0 && sec_tens == 3'h0;
  endproperty
  a_hold_zero: assert property (p_hold_zero) else $error("seconds not held at zero");

  property p_sec_on_tick;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      !sec_rst && !tick1 |=> $stable(sec_ones_r);
  endproperty
  a_sec_on_tick: assert property (p_sec_on_tick) else $error("seconds moved without tick");

  property p_slow_rate;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      slow_set && !fast_set && !hold && tick8 |=> $changed(min_ones_seg_o);
  endproperty
  a_slow_rate: assert property (p_slow_rate) else $error("slow set did not step minutes");

  property p_hold_freeze;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      hold |=> $stable(min_ones_seg_o) && $stable(hr_r);
  endproperty
  a_hold_freeze: assert property (p_hold_freeze) else $error("time moved during hold");

  property p_noon_carry;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      s_eleven_step |=> s_pm_flipped;
  endproperty
  a_noon_carry: assert property (p_noon_carry) else $error("no meridiem change at 12");

  property p_reset_time;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      time_rst |-> !pm_o ##1 (hr_r == 4'hC && min_ones_seg_o == 7'h3F && !pm_r);
  endproperty
  a_reset_time: assert property (p_reset_time) else $error("time reset not 12:00 AM");

  property p_hour_range;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      hr_r >= 4'h1 && hr_r <= 4'hC;
  endproperty
  a_hour_range: assert property (p_hour_range) else $error("hour count out of range");

  property p_roll_to_one;
    @(posedge ref_clk_i) disable iff (!arst_n_i)
      hr_adv && !time_rst && hr_r == 4'hC |=> hr_r == 4'h1 && $stable(pm_r);
  endproperty
  a_roll_to_one: assert property (p_roll_to_one) else $error("carry at rollover");
endmodule // time_of_day_display_counters

/* File: dv/switch_display_model.sv */
/*
 Front panel model: the three setting switches and the four segment displays.
 Assumes the bench asks for switch levels and reads back decoded digits.
*/
`timescale 1ns/1ps
module switch_display_model (
  // Clock and bench requests {hold,fast,slow}
  input wire logic ref_clk_i,
  input wire logic [2:0] press_i,
  // Segment inputs
  input wire logic [6:0] min_ones_seg_i,
  input wire logic [6:0] min_tens_seg_i,
  input wire logic [6:0] hr_ones_seg_i,
  input wire logic [6:0] hr_tens_seg_i,
  // Switch pins and decoded display
  output logic slow_set_pin_o,
  output logic fast_set_pin_o,
  output logic hold_pin_o,
  output logic [7:0] minute_o,
  output logic [4:0] hour_o
);
  // Patterns outside the table decode to 15 so they never pass for a digit.
  function automatic logic [7:0] dig(input logic [6:0] s);
    case (s)
      7'h3F: dig = 8'h00;
      7'h06: dig = 8'h01;
      7'h5B: dig = 8'h02;
      7'h4F: dig = 8'h03;
      7'h66: dig = 8'h04;
      7'h6D: dig = 8'h05;
      7'h7C: dig = 8'h06;
      7'h07: dig = 8'h07;
      7'h7F: dig = 8'h08;
      7'h6F: dig = 8'h09;
      default: dig = 8'h0F;
    endcase
  endfunction

  initial {hold_pin_o, fast_set_pin_o, slow_set_pin_o} = 3'h0;
  always @(posedge ref_clk_i) begin
    {hold_pin_o, fast_set_pin_o, slow_set_pin_o} <= press_i;
  end
  assign minute_o = dig(min_tens_seg_i) * 8'h0A + dig(min_ones_seg_i);
  assign hour_o = (hr_tens_seg_i == 7'h00) ? 5'(dig(hr_ones_seg_i)) :
                  (hr_tens_seg_i == 7'h06) ? 5'(dig(hr_ones_seg_i) + 8'h0A) : 5'h1F;
endmodule // switch_display_model

/* File: dv/testbench.sv */
/*
 Self-checking bench for the time-of-day counter chain.
 Assumes a shortened prescaler and the front panel model in its own file.
*/
`timescale 1ns/1ps
module testbench;
  localparam int TICK = 4;
  localparam int FAST_GAP = TICK;
  localparam int SLOW_GAP = TICK * 16;
  localparam int SEC_GAP = TICK * 128;
  logic ref_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic awvalid_i = 1'b0;
  logic wvalid_i = 1'b0;
  logic bready_i = 1'b0;
  logic arvalid_i = 1'b0;
  logic rready_i = 1'b0;
  logic [31:0] awaddr_i = '0;
  logic [31:0] wdata_i = '0;
  logic [31:0] araddr_i = '0;
  logic [3:0] wstrb_i = 4'hF;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, pm_o;
  logic slow_set_pin_i, fast_set_pin_i, hold_pin_i;
  logic [1:0] bresp_o, rresp_o;
  logic [31:0] rdata_o;
  logic [3:0] sec_ones_o;
  logic [2:0] sec_tens_o;
  logic [6:0] min_ones_seg_o, min_tens_seg_o, hr_ones_seg_o, hr_tens_seg_o;
  logic [2:0] press = 3'h0;
  logic [7:0] minute;
  logic [4:0] hour;
  int fail_count = 0;
  int compares = 0;
  int cycles = 0;

  time_of_day_display_counters #(.TICK128_CYCLES(TICK)) DUT (
    .ref_clk_i, .arst_n_i, .awvalid_i, .awready_o, .awaddr_i, .wvalid_i, .wready_o,
    .wdata_i, .wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o,
    .araddr_i, .rvalid_o, .rready_i, .rdata_o, .rresp_o, .slow_set_pin_i,
    .fast_set_pin_i, .hold_pin_i, .sec_ones_o, .sec_tens_o, .min_ones_seg_o,
    .min_tens_seg_o, .hr_ones_seg_o, .hr_tens_seg_o, .pm_o);

  switch_display_model panel (
    .ref_clk_i, .press_i(press), .min_ones_seg_i(min_ones_seg_o),
    .min_tens_seg_i(min_tens_seg_o), .hr_ones_seg_i(hr_ones_seg_o),
    .hr_tens_seg_i(hr_tens_seg_o), .slow_set_pin_o(slow_set_pin_i),
    .fast_set_pin_o(fast_set_pin_i), .hold_pin_o(hold_pin_i), .minute_o(minute),
    .hour_o(hour));

  always #10 ref_clk_i = ~ref_clk_i;

  task automatic wrap_up();
    if (fail_count == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 100000) begin
      fail_count++;
      wrap_up();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [31:0] sec_now();
    return sec_tens_o * 10 + sec_ones_o;
  endfunction

  task automatic axi_write(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    awaddr_i <= a;
    wdata_i <= d;
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
    end while (bvalid_o !== 1'b1);
    r = bresp_o;
    bready_i <= 1'b0;
  endtask

  task automatic axi_read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    do begin
      @(posedge ref_clk_i);
      if (arready_o) arvalid_i <= 1'b0;
    end while (rvalid_o !== 1'b1);
    d = rdata_o;
    r = rresp_o;
    rready_i <= 1'b0;
  endtask

  task automatic t_reset();
    logic [31:0] d;
    logic [1:0] r;
    check("seconds", 0, sec_now());
    check("min_ones_seg", clock_pkg::SEG_ZERO, min_ones_seg_o);
    check("min_tens_seg", clock_pkg::SEG_ZERO, min_tens_seg_o);
    check("hour", 12, hour);
    check("pm", 0, pm_o);
    axi_read(clock_pkg::SEGMENT_OFFSET, d, r);
    check("segment_reg", {4'h0, 7'h06, 7'h5B, 7'h3F, 7'h3F}, d);
    check("segment_resp", clock_pkg::RESP_OKAY, r);
  endtask

  // Seconds run free for one full minute, then the minute digit must step.
  task automatic t_seconds();
    int s;
    int gap;
    s = 0;
    for (int k = 1; k <= 60; k++) begin
      gap = 0;
      while (sec_now() == s) begin
        @(posedge ref_clk_i);
        gap++;
      end
      s = (s + 1) % 60;
      check("seconds", s, sec_now());
      if (k > 1) check("second_gap", SEC_GAP, gap);
    end
    repeat (3) @(posedge ref_clk_i);
    check("minute", 1, minute);
  endtask

  // A set switch steps minutes and hours at its own rate; seconds stay cleared.
  task automatic t_set(input logic [2:0] code, input int step_gap, input int steps);
    int m;
    int h;
    int gap;
    logic p;
    press <= code;
    repeat (8) @(posedge ref_clk_i);
    check("seconds_cleared", 0, sec_now());
    m = minute;
    h = hour;
    p = pm_o;
    for (int k = 1; k <= steps; k++) begin
      gap = 0;
      while (minute == m) begin
        @(posedge ref_clk_i);
        gap++;
      end
      m = (m + 1) % 60;
      if (m == 0) h = h % 12 + 1;
      if (m == 0 && h == 12) p = !p;
      check("minute", m, minute);
      check("hour", h, hour);
      check("pm", p, pm_o);
      if (k > 1) check("step_gap", step_gap, gap);
    end
  endtask

  task automatic t_hold();
    logic [7:0] m0;
    press <= 3'b100;
    repeat (8) @(posedge ref_clk_i);
    m0 = minute;
    repeat (3 * SLOW_GAP) begin
      @(posedge ref_clk_i);
      check("held_seconds", 0, sec_now());
      check("held_minute", m0, minute);
    end
  endtask

  task automatic t_clear();
    press <= 3'b011;
    repeat (8) @(posedge ref_clk_i);
    check("minute", 0, minute);
    check("hour", 12, hour);
    check("pm", 0, pm_o);
    press <= 3'b000;
    @(posedge ref_clk_i);
  endtask

  task automatic t_axi();
    logic [31:0] d;
    logic [1:0] r;
    axi_write(clock_pkg::CTRL_OFFSET, 32'h0000_0004, r);
    check("ctrl_resp", clock_pkg::RESP_OKAY, r);
    repeat (3) @(posedge ref_clk_i);
    axi_read(clock_pkg::STATUS_OFFSET, d, r);
    check("status_hold_hour", 32'h0000_1C00, d & 32'h0000_1F00);
    check("status_secs", 0, d & 32'h0000_007F);
    axi_write(32'h0000_0040, 32'h0000_0007, r);
    check("bad_write_resp", clock_pkg::RESP_SLVERR, r);
    axi_read(32'h0000_0040, d, r);
    check("bad_read_data", 0, d);
    check("bad_read_resp", clock_pkg::RESP_SLVERR, r);
    axi_write(clock_pkg::CTRL_OFFSET, 32'h0000_0000, r);
    check("ctrl_resp", clock_pkg::RESP_OKAY, r);
  endtask

  initial begin
    repeat (4) @(posedge ref_clk_i);
    arst_n_i <= 1'b1;
    @(posedge ref_clk_i);
    t_reset();
    t_seconds();
    t_set(3'b010, FAST_GAP, 730);
    t_set(3'b001, SLOW_GAP, 4);
    t_hold();
    t_clear();
    t_axi();
    wrap_up();
  end
endmodule // testbench
